// ==== src/sfb_pkg.sv ====
// package: register map, field layout and constants of the serial channel pair
package sfb_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          CHAN_STRIDE     = 8;
    localparam logic [3:0]  OFF_BAUD_HIGH   = 4'h0;
    localparam logic [3:0]  OFF_BAUD_LOW    = 4'h1;
    localparam logic [3:0]  OFF_CTRL1       = 4'h2;
    localparam logic [3:0]  OFF_CTRL2       = 4'h3;
    localparam logic [3:0]  OFF_STATUS      = 4'h4;
    localparam logic [3:0]  OFF_DATA_HIGH   = 4'h6;
    localparam logic [3:0]  OFF_DATA_LOW    = 4'h7;
    localparam logic [15:0] BAUD_RESET      = 16'h0004;
    localparam int          DIV_W           = 13;
    localparam int          OVERSAMPLE      = 16;
    localparam logic [3:0]  OS_LAST         = 4'hF;
    localparam logic [3:0]  OS_MID          = 4'h7;
    localparam logic [3:0]  OS_BEFORE_MID   = 4'h6;
    localparam logic [3:0]  OS_AFTER_MID    = 4'h8;
    localparam int          CTL1_LOOP       = 7;
    localparam int          CTL1_WIRED      = 6;
    localparam int          CTL1_RSRC       = 5;
    localparam int          CTL1_NINE       = 4;
    localparam int          CTL1_PARITY_ON  = 1;
    localparam int          CTL1_PARITY_ODD = 0;
    localparam int          CTL2_RX_IRQ     = 5;
    localparam int          CTL2_TX_ON      = 3;
    localparam int          CTL2_RX_ON      = 2;
    localparam int          CTL2_BREAK      = 0;
    localparam int          ST_TX_EMPTY     = 7;
    localparam int          ST_TX_DONE      = 6;
    localparam int          ST_RX_FULL      = 5;
    localparam int          ST_OVERRUN      = 3;
    localparam int          ST_FRAME_ERR    = 1;
    localparam int          ST_PARITY_ERR   = 0;
    localparam logic [3:0]  BITS_EIGHT      = 4'h9;
    localparam logic [3:0]  BITS_NINE       = 4'hA;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        chan;
        logic [2:0]  offset;
        logic [7:0]  wdata;
    } sfb_bus_type;

    typedef struct packed {
        logic tx_out;
        logic tx_oe_n;
        logic rx_out;
        logic rx_oe_n;
    } sfb_pins_type;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_SHIFT = 4'b0010,
        TX_BREAK = 4'b0100,
        TX_STOP  = 4'b1000
    } sfb_tx_state_type;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } sfb_rx_state_type;
endpackage

// ==== src/sfb_top.sv ====
// two serial channels with baud generators, framing, parity and pin sharing
`timescale 1ns/10ps
module sfb_top (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    input  wire logic [sfb_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]                wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic      [7:0]                rdata,
    input  wire logic                      special_mode,
    input  wire logic                      wait_state,
    input  wire logic                      pll_supply_rail,
    input  wire logic [1:0]                tx_pin_in,
    input  wire logic [1:0]                rx_pin_in,
    input  wire logic [1:0]                gp_tx_out,
    input  wire logic [1:0]                gp_tx_oe_n,
    input  wire logic [1:0]                gp_rx_out,
    input  wire logic [1:0]                gp_rx_oe_n,
    output logic      [1:0]                tx_pin_out,
    output logic      [1:0]                tx_pin_oe_n,
    output logic      [1:0]                rx_pin_out,
    output logic      [1:0]                rx_pin_oe_n,
    output logic      [1:0]                irq
);
    // one decoded bus request; channel from address bit 3 (eight-byte blocks)
    sfb_pkg::sfb_bus_type bus;
    assign bus = '{wr: wr_stb, rd: rd_stb, chan: addr[3], offset: addr[2:0], wdata: wdata};

    function automatic logic hit(input sfb_pkg::sfb_bus_type b, input logic ch, input logic [3:0] off);
        hit = (b.chan == ch) && ({1'b0, b.offset} == off);
    endfunction

    function automatic logic [8:0] mask_data(input logic [8:0] d, input logic nine);
        mask_data = nine ? d : {1'b0, d[7:0]};
    endfunction

    logic [7:0] ch_rdata [2];
    logic [7:0] next_rdata;
    assign next_rdata = bus.rd ? ch_rdata[bus.chan] : 8'h00;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [15:0] baud;
            logic [15:0] baud_live;
            logic [7:0]  ctrl1;
            logic [7:0]  ctrl2;
            logic        armed;
            logic [sfb_pkg::DIV_W-1:0] div_cnt;
            logic        tick;
            logic        tx_empty, tx_done, rx_full, overrun, frame_err, parity_err;
            logic [8:0]  tx_hold;
            logic [8:0]  rx_hold;
            logic [10:0] tx_shift;
            logic [3:0]  tx_bits, tx_os;
            sfb_pkg::sfb_tx_state_type tx_state;
            sfb_pkg::sfb_rx_state_type rx_state;
            logic [3:0]  rx_os, rx_bits;
            logic [9:0]  rx_shift;
            logic [2:0]  rx_vote;
            logic        rx_active;
            logic        irq_q;
            logic        status_seen;
            sfb_pkg::sfb_pins_type pins;

            logic        w_bh, w_bl, w_c1, w_c2, w_dl, r_dl, r_st;
            assign w_bh = bus.wr && hit(bus, ch[0], sfb_pkg::OFF_BAUD_HIGH);
            assign w_bl = bus.wr && hit(bus, ch[0], sfb_pkg::OFF_BAUD_LOW);
            assign w_c1 = bus.wr && hit(bus, ch[0], sfb_pkg::OFF_CTRL1);
            assign w_c2 = bus.wr && hit(bus, ch[0], sfb_pkg::OFF_CTRL2);
            assign w_dl = bus.wr && hit(bus, ch[0], sfb_pkg::OFF_DATA_LOW);
            assign r_dl = bus.rd && hit(bus, ch[0], sfb_pkg::OFF_DATA_LOW);
            assign r_st = bus.rd && hit(bus, ch[0], sfb_pkg::OFF_STATUS);

            logic nine, par_on, par_odd, loop_on, rsrc, tx_on, rx_on;
            assign nine    = ctrl1[sfb_pkg::CTL1_NINE];
            assign par_on  = ctrl1[sfb_pkg::CTL1_PARITY_ON];
            assign par_odd = ctrl1[sfb_pkg::CTL1_PARITY_ODD];
            assign loop_on = ctrl1[sfb_pkg::CTL1_LOOP];
            assign rsrc    = ctrl1[sfb_pkg::CTL1_RSRC];
            assign tx_on   = ctrl2[sfb_pkg::CTL2_TX_ON];
            assign rx_on   = ctrl2[sfb_pkg::CTL2_RX_ON];

            // high byte is staged; the divisor used by the counter changes only on a low-byte write
            logic [15:0] next_baud;
            assign next_baud = w_bh ? {(special_mode ? bus.wdata[7:5] : baud[15:13]), bus.wdata[4:0], baud[7:0]}
                             : w_bl ? {baud[15:8], bus.wdata} : baud;

            // bus read mux; reserved offsets read as zero
            logic [7:0] status;
            assign status = {tx_empty, tx_done, rx_full, rx_active, overrun, 1'b0, frame_err, parity_err};
            always_comb begin
                case (bus.offset)
                    3'h0:    ch_rdata[ch] = baud[15:8];
                    3'h1:    ch_rdata[ch] = baud[7:0];
                    3'h2:    ch_rdata[ch] = ctrl1;
                    3'h3:    ch_rdata[ch] = ctrl2;
                    3'h4:    ch_rdata[ch] = status;
                    3'h6:    ch_rdata[ch] = {7'h00, rx_hold[8]};
                    3'h7:    ch_rdata[ch] = rx_hold[7:0];
                    default: ch_rdata[ch] = 8'h00;
                endcase
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    baud      <= sfb_pkg::BAUD_RESET;
                    baud_live <= sfb_pkg::BAUD_RESET;
                    ctrl1     <= 8'h00;
                    ctrl2     <= 8'h00;
                    armed     <= 1'b0;
                end else begin
                    baud  <= next_baud;
                    ctrl1 <= w_c1 ? bus.wdata : ctrl1;
                    ctrl2 <= w_c2 ? bus.wdata : ctrl2;
                    if (w_bl) begin
                        baud_live <= next_baud;
                    end
                    // armed stays set until reset, so clearing both enables does not stop the generator
                    if (tx_on || rx_on) begin
                        armed <= 1'b1;
                    end
                end
            end

            // modulus counter: one tick per divisor clocks (sixteen per bit)
            logic gen_run;
            logic div_wrap;
            // >= rather than == so a smaller new divisor wraps at once instead of running on to the top
            assign div_wrap = div_cnt >= baud_live[12:0] - 13'h0001;
            assign gen_run = armed && (baud_live[12:0] != 13'h0000);
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    div_cnt <= 13'h0000;
                    tick    <= 1'b0;
                end else if (!gen_run) begin
                    div_cnt <= 13'h0000;
                    tick    <= 1'b0;
                end else begin
                    tick    <= div_wrap;
                    div_cnt <= div_wrap ? 13'h0000 : div_cnt + 13'h0001;
                end
            end

            // transmitter; parity replaces the top data bit
            logic [8:0] tx_data;
            logic       tx_par;
            assign tx_data = mask_data(tx_hold, nine);
            assign tx_par  = (nine ? ^tx_data[7:0] : ^tx_data[6:0]) ^ par_odd;
            logic [8:0] tx_word;
            assign tx_word = !par_on ? tx_data : nine ? {tx_par, tx_data[7:0]} : {1'b0, tx_par, tx_data[6:0]};
            logic [3:0] frame_bits;
            assign frame_bits = nine ? sfb_pkg::BITS_NINE : sfb_pkg::BITS_EIGHT;
            logic tx_line;
            assign tx_line = (tx_state == sfb_pkg::TX_IDLE) ? 1'b1 : tx_shift[0];

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    tx_state <= sfb_pkg::TX_IDLE;
                    tx_shift <= 11'h7FF;
                    tx_bits  <= 4'h0;
                    tx_os    <= 4'h0;
                    tx_hold  <= 9'h000;
                    tx_empty <= 1'b1;
                    tx_done  <= 1'b1;
                end else begin
                    if (w_dl) begin
                        tx_hold  <= {tx_hold[8], bus.wdata};
                        tx_empty <= 1'b0;
                        tx_done  <= 1'b0;
                    end
                    if (bus.wr && hit(bus, ch[0], sfb_pkg::OFF_DATA_HIGH)) begin
                        tx_hold[8] <= bus.wdata[0];
                    end
                    if (tick) begin
                        tx_os <= tx_os + 4'h1;
                    end
                    case (tx_state)
                        sfb_pkg::TX_IDLE: begin
                            if (tick && tx_on && ctrl2[sfb_pkg::CTL2_BREAK]) begin
                                tx_state <= sfb_pkg::TX_BREAK;
                                tx_shift <= 11'h000;
                                tx_bits  <= frame_bits;
                                tx_os    <= 4'h0;
                                tx_done  <= 1'b0;
                            end else if (tick && tx_on && !tx_empty && !w_dl) begin
                                tx_state <= sfb_pkg::TX_SHIFT;
                                tx_shift <= nine ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
                                tx_bits  <= frame_bits;
                                tx_os    <= 4'h0;
                                tx_empty <= 1'b1;
                            end else if (tick && tx_empty) begin
                                tx_done  <= 1'b1;
                            end
                        end
                        sfb_pkg::TX_SHIFT, sfb_pkg::TX_BREAK: begin
                            if (tick && tx_os == sfb_pkg::OS_LAST) begin
                                tx_shift <= {tx_state == sfb_pkg::TX_SHIFT, tx_shift[10:1]};
                                tx_bits  <= tx_bits - 4'h1;
                                if (tx_bits == 4'h0) begin
                                    tx_state <= (tx_state == sfb_pkg::TX_BREAK && ctrl2[sfb_pkg::CTL2_BREAK])
                                              ? sfb_pkg::TX_BREAK : sfb_pkg::TX_STOP;
                                    tx_bits  <= frame_bits;
                                    tx_shift <= (tx_state == sfb_pkg::TX_BREAK) ? 11'h000 : 11'h7FF;
                                end
                            end
                        end
                        sfb_pkg::TX_STOP: begin
                            tx_state <= sfb_pkg::TX_IDLE;
                            tx_shift <= 11'h7FF;
                        end
                        default: tx_state <= sfb_pkg::TX_IDLE;
                    endcase
                end
            end

            // receiver input source: pin, internal loop, or the transmit pin in single-wire mode
            logic rx_src;
            assign rx_src = !loop_on ? rx_pin_in[ch] : rsrc ? tx_pin_in[ch] : tx_line;

            logic [8:0] rx_word;
            logic       rx_par_bad;
            // data enters at the top, so nine bits end up in [9:1] and eight bits in [9:2]
            assign rx_word    = nine ? rx_shift[9:1] : {1'b0, rx_shift[9:2]};
            assign rx_par_bad = par_on && ((nine ? ^rx_word[8:0] : ^rx_word[7:0]) != par_odd);
            // two of three samples high means the low level was a glitch, not a start bit
            logic start_false;
            assign start_false = (rx_vote[0] & rx_vote[1]) | (rx_vote[1] & rx_vote[2]) | (rx_vote[0] & rx_vote[2]);

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    rx_state    <= sfb_pkg::RX_IDLE;
                    rx_os       <= 4'h0;
                    rx_bits     <= 4'h0;
                    rx_shift    <= 10'h000;
                    rx_vote     <= 3'h0;
                    rx_hold     <= 9'h000;
                    rx_full     <= 1'b0;
                    overrun     <= 1'b0;
                    frame_err   <= 1'b0;
                    parity_err  <= 1'b0;
                    rx_active   <= 1'b0;
                    status_seen <= 1'b0;
                end else begin
                    if (r_st) begin
                        status_seen <= 1'b1;
                    end
                    // a new character on the same edge as the clearing read wins
                    if (r_dl && status_seen) begin
                        rx_full     <= 1'b0;
                        overrun     <= 1'b0;
                        frame_err   <= 1'b0;
                        parity_err  <= 1'b0;
                        status_seen <= 1'b0;
                    end
                    if (!rx_on) begin
                        rx_state  <= sfb_pkg::RX_IDLE;
                        rx_active <= 1'b0;
                    end else if (tick) begin
                        rx_os <= rx_os + 4'h1;
                        case (rx_state)
                            sfb_pkg::RX_IDLE: begin
                                rx_os <= 4'h0;
                                if (!rx_src) begin
                                    rx_state  <= sfb_pkg::RX_START;
                                    rx_active <= 1'b1;
                                    rx_vote   <= 3'h0;
                                end
                            end
                            sfb_pkg::RX_START: begin
                                if (rx_os >= sfb_pkg::OS_BEFORE_MID && rx_os <= sfb_pkg::OS_AFTER_MID) begin
                                    rx_vote <= {rx_vote[1:0], rx_src};
                                end
                                if (rx_os == sfb_pkg::OS_AFTER_MID + 4'h1) begin
                                    // two of three low samples confirm the start bit
                                    if (start_false) begin
                                        rx_state  <= sfb_pkg::RX_IDLE;
                                        rx_active <= 1'b0;
                                    end else begin
                                        rx_state <= sfb_pkg::RX_DATA;
                                        rx_bits  <= frame_bits - 4'h1;
                                    end
                                end
                            end
                            sfb_pkg::RX_DATA: begin
                                if (rx_os == sfb_pkg::OS_MID) begin
                                    rx_shift <= {rx_src, rx_shift[9:1]};
                                    rx_bits  <= rx_bits - 4'h1;
                                    if (rx_bits == 4'h1) begin
                                        rx_state <= sfb_pkg::RX_STOP;
                                    end
                                end
                            end
                            sfb_pkg::RX_STOP: begin
                                if (rx_os == sfb_pkg::OS_MID) begin
                                    rx_state  <= sfb_pkg::RX_IDLE;
                                    rx_active <= 1'b0;
                                    rx_hold   <= rx_word;
                                    rx_full   <= 1'b1;
                                    overrun   <= overrun | rx_full;
                                    frame_err <= !rx_src;
                                    parity_err <= rx_par_bad;
                                end
                            end
                            default: rx_state <= sfb_pkg::RX_IDLE;
                        endcase
                    end
                end
            end

            // pin sharing: serial function claims pins only when enabled
            logic tx_claim, rx_claim;
            // loop or single-wire without port drive lets go of the pin, so an outside sender is not fought
            assign tx_claim = tx_on && !(loop_on && gp_tx_oe_n[ch]);
            assign rx_claim = rx_on && !loop_on;
            assign pins = '{tx_out:  tx_claim ? tx_line : gp_tx_out[ch],
                            tx_oe_n: tx_claim ? 1'b0 : gp_tx_oe_n[ch],
                            rx_out:  gp_rx_out[ch],
                            rx_oe_n: rx_claim ? 1'b1 : gp_rx_oe_n[ch]};

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    tx_pin_out[ch]  <= 1'b1;
                    tx_pin_oe_n[ch] <= 1'b1;
                    rx_pin_out[ch]  <= 1'b1;
                    rx_pin_oe_n[ch] <= 1'b1;
                    irq_q           <= 1'b0;
                end else begin
                    tx_pin_out[ch]  <= pins.tx_out;
                    tx_pin_oe_n[ch] <= pins.tx_oe_n;
                    rx_pin_out[ch]  <= pins.rx_out;
                    rx_pin_oe_n[ch] <= pins.rx_oe_n;
                    irq_q <= ctrl2[sfb_pkg::CTL2_RX_IRQ] && (rx_full || overrun ||
                             (rx_active && wait_state && pll_supply_rail));
                end
            end
            assign irq[ch] = irq_q;
        end
    endgenerate
endmodule

// ==== tb/sfb_remote.sv ====
// remote transceiver driving channel 0 receive line
`timescale 1ns/10ps
module sfb_remote (
    input  wire logic clk,
    output logic      line
);
    initial line = 1'b1;
    // bad flips parity so the receiver check is exercised
    task automatic send(input logic [6:0] d, input logic bad);
        logic [9:0] fr;
        fr = {1'b1, ^d ^ bad, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= fr[i];
            repeat (16) @(posedge clk);
        end
    endtask
endmodule

// ==== tb/sfb_top_checker.sv ====
// port assertions for the serial channel pair
`timescale 1ns/10ps
module sfb_top_checker (
    input wire logic                       clk,
    input wire logic                       arst_n,
    input wire logic [sfb_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0]                 wdata,
    input wire logic                       wr_stb,
    input wire logic                       rd_stb,
    input wire logic [7:0]                 rdata,
    input wire logic                       special_mode,
    input wire logic [1:0]                 gp_tx_out,
    input wire logic [1:0]                 tx_pin_out,
    input wire logic [1:0]                 irq
);
    // channel 0 baud register as software should read it back
    logic [15:0] b0;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b0 <= sfb_pkg::BAUD_RESET;
        end else if (wr_stb && addr == 4'h0) begin
            b0[15:8] <= special_mode ? wdata : {b0[15:13], wdata[4:0]};
        end else if (wr_stb && addr == 4'h1) begin
            b0[7:0] <= wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rd_idle; !$past(rd_stb) |-> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
    property p_unmap; $past(rd_stb) && ($past(addr) & 4'h7) == 4'h5 |-> rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_baud_hi; $past(rd_stb) && $past(addr) == 4'h0 |-> {8'h00, rdata} == $past(b0) >> 8; endproperty
    a_baud_hi: assert property (p_baud_hi) else $error("baud high wrong");
    property p_baud_lo; $past(rd_stb) && $past(addr) == 4'h1 |-> {8'h00, rdata} == ($past(b0) & 16'h00FF); endproperty
    a_baud_lo: assert property (p_baud_lo) else $error("baud low wrong");
    property p_low_bit; $fell(tx_pin_out[0]) |-> !tx_pin_out[0] [*8] ##1 !tx_pin_out[0] [*8]; endproperty
    a_low_bit: assert property (p_low_bit) else $error("low bit too short");
    property p_high_bit; $rose(tx_pin_out[0]) |-> tx_pin_out[0] [*8] ##1 tx_pin_out[0] [*8]; endproperty
    a_high_bit: assert property (p_high_bit) else $error("high bit too short");
    property p_rst_idle; $rose(arst_n) |-> tx_pin_out[0] && irq == 2'b00; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("line not idle after reset");
    property p_gp; {tx_pin_out[1], 1'b0} == ($past(gp_tx_out) & 2'b10); endproperty
    a_gp: assert property (p_gp) else $error("port pin not passed");
    c_tx: cover property ($fell(tx_pin_out[0]));
    c_irq: cover property ($rose(irq[0]));
    c_spc: cover property (wr_stb && special_mode);
endmodule
bind sfb_top sfb_top_checker u_chk (.clk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .special_mode,
    .gp_tx_out, .tx_pin_out, .irq);

// ==== tb/sfb_top_tb.sv ====
// self-checking bench for the serial channel pair
`timescale 1ns/10ps
module sfb_top_tb;
    logic        clk, arst_n, wr_stb, rd_stb, special_mode, wait_state, pll_supply_rail, rem_line;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, s;
    logic [1:0]  gp_tx_out, gp_tx_oe_n, gp_rx_out, gp_rx_oe_n, irq;
    logic [1:0]  tx_pin_out, tx_pin_oe_n, rx_pin_out, rx_pin_oe_n;
    logic [10:0] f, e;
    logic [7:0]  cfg [3] = '{8'h02, 8'h03, 8'h13};
    int          n_errors = 0;
    int          checks_done = 0;
    sfb_top u_dut (.clk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .special_mode, .wait_state,
        .pll_supply_rail, .tx_pin_in(tx_pin_out | tx_pin_oe_n), .rx_pin_in({rx_pin_out[1] | rx_pin_oe_n[1], rem_line}),
        .gp_tx_out, .gp_tx_oe_n, .gp_rx_out, .gp_rx_oe_n, .tx_pin_out, .tx_pin_oe_n, .rx_pin_out, .rx_pin_oe_n, .irq);
    sfb_remote u_rem (.clk, .line(rem_line));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // samples each bit at its centre, one divisor of 1 gives 16 clocks a bit
    task automatic grab(output logic [10:0] fr);
        int k;
        k = 0;
        while (tx_pin_out[0] !== 1'b0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            #1 fr[i] = tx_pin_out[0];
            repeat (16) @(posedge clk);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        {arst_n, wr_stb, rd_stb, special_mode, wait_state, pll_supply_rail, addr, wdata} = '0;
        {gp_tx_out, gp_tx_oe_n, gp_rx_out, gp_rx_oe_n} = 8'hFF;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(4'h1, s);
        check(s, sfb_pkg::BAUD_RESET[7:0]);
        wr(4'h0, 8'hE0);
        rd(4'h0, s);
        check(s, sfb_pkg::BAUD_RESET[15:8]);
        special_mode <= 1'b1;
        wr(4'h0, 8'hE0);
        rd(4'h0, s);
        check(s, 8'hE0);
        wr(4'h1, 8'h01);
        rd(4'h9, s);
        check(s, sfb_pkg::BAUD_RESET[7:0]);
        rd(4'h5, s);
        check(s, 8'h00);
        wr(4'h2, 8'h02);
        wr(4'h3, 8'h2C);
        rd(4'h4, s);
        check(tx_pin_oe_n[0], 1'b0);
        for (int b = 0; b < 2; b++) begin
            u_rem.send(7'h35, b[0]);
            repeat (24) @(posedge clk);
            rd(4'h4, s);
            check({s[sfb_pkg::ST_RX_FULL], s[sfb_pkg::ST_PARITY_ERR]}, {1'b1, b[0]});
            rd(4'h7, s);
            check(s[6:0], 7'h35);
        end
        for (int c = 3; c > 0; c--) begin
            {wait_state, pll_supply_rail} <= c[1:0];
            fork
                u_rem.send(7'h11, 1'b0);
                begin
                    repeat (60) @(posedge clk);
                    #1 check(irq[0], c == 3);
                end
            join
            rd(4'h4, s);
            rd(4'h7, s);
        end
        {gp_tx_out, gp_tx_oe_n, gp_rx_out, gp_rx_oe_n} <= 8'h50;
        repeat (2) @(posedge clk);
        #1 check({tx_pin_out[1], tx_pin_oe_n[1], rx_pin_out[1], rx_pin_oe_n[1], rx_pin_oe_n[0]}, 5'b00001);
        foreach (cfg[i]) begin
            wr(4'h2, cfg[i]);
            rd(4'h4, s);
            wr(4'h7, 8'hB5);
            grab(f);
            e = cfg[i][4] ? {1'b1, ^8'hB5 ^ cfg[i][0], 8'hB5, 1'b0} : {2'b11, ^7'h35 ^ cfg[i][0], 7'h35, 1'b0};
            check(f, e);
        end
        wr(4'h2, 8'h90);
        wr(4'h6, 8'h01);
        wr(4'h7, 8'hA5);
        repeat (200) @(posedge clk);
        rd(4'h6, s);
        check(s, 8'h01);
        rd(4'h7, s);
        check(s, 8'hA5);
        wr(4'h3, 8'h2D);
        repeat (100) @(posedge clk);
        wr(4'h3, 8'h2C);
        repeat (200) @(posedge clk);
        rd(4'h4, s);
        check({s[sfb_pkg::ST_RX_FULL], s[sfb_pkg::ST_FRAME_ERR]}, 2'b11);
        rd(4'h7, s);
        check(s, 8'h00);
        stop_test();
    end
endmodule
